// ### eos_pkg.sv
package eos_pkg;

	// tx signaling and link select: printed offset is an index, byte address is four times it
	localparam logic [11:0] TSLS_INDEX      = 12'h10A;
	localparam logic [11:0] TSLS_ADDR       = 12'h428;
	localparam logic [11:0] LINK_CFG_ADDR   = 12'h430;
	localparam logic [11:0] STATUS_ADDR     = 12'h434;

	localparam int          SA4_EN_BIT      = 3;
	localparam logic [7:0]  TSLS_RESET      = 8'h00;
	localparam logic [7:0]  LINK_CFG_RESET  = 8'h00;
	localparam logic [1:0]  LINK_SRC_HDLC   = 2'h1;
	localparam logic [4:0]  SLOT_FRAMING    = 5'h00;
	localparam logic [4:0]  SLOT_SIGNALING  = 5'h10;
	localparam logic [2:0]  SA4_BIT_POS     = 3'h3;
	localparam logic [2:0]  SA8_BIT_POS     = 3'h7;

	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	typedef enum logic [2:0] {
		OSS_SER_LINK      = 3'h0,
		OSS_CAS_LINK      = 3'h1,
		OSS_SIG_ONES      = 3'h2,
		OSS_CAS_ONES      = 3'h3,
		OSS_DESIG_LINK    = 3'h4
	} eos_oss_t;

	// timeslot 16 sub-source when a code offers more than one
	typedef enum logic [1:0] {
		TS16_SERIAL  = 2'h0,
		TS16_REGS    = 2'h1,
		TS16_OVHD    = 2'h2,
		TS16_SIGIN   = 2'h3
	} eos_ts16_t;

	// position of the bit now being sent, from the framer timing
	typedef struct packed {
		logic       nonFas;
		logic [4:0] slot;
		logic [2:0] bitPos;
		logic       deSlot;
	} eos_pos_t;

	// candidate bit sources for the current bit time
	typedef struct packed {
		logic serial;
		logic fractional;
		logic signaling;
		logic overhead;
		logic casReg;
		logic saReg;
		logic hdlc;
	} eos_src_t;

endpackage : eos_pkg

// ### eos_source_select.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
// What this block does
// R01 - Sa4 link enable low: Sa4 carries no data-link bits.
// R02 - enable low and Sa4 from serial input: every Sa4 bit sent as one.
// R03 - enable high with code 000, 001 or 100: Sa4 positions carry outgoing data-link bits.
// R04 - link bits go to Sa4 only if link source is HDLC and serial insert chosen.
// R05 - three-bit select sets D/E, national bits and timeslot 16 sources together, as one combination per code.
// R06 - codes 000 and 100: serial slot 16, link national bits; 100 uses signaling D/E.
// R07 - code 001: CAS on, slot 16 from serial, registers or overhead; link bits.
// R08 - code 010: national bits all ones, slot 16 from serial or signaling input.
// R09 - code 011: ones national bits, CAS on, slot 16 from any of four sources.
// R10 - codes 101 to 111 reserved and undefined; software must not program them.
module eos_source_select
	import eos_pkg::*;
(
	input  wire logic        sys_clk,        // 250 MHz channel clock
	input  wire logic        rst_n,          // async reset, active low
	input  wire logic [11:0] s_axi_awaddr,   // write address
	input  wire logic        s_axi_awvalid,  // write address valid
	output logic             s_axi_awready,  // write address ready
	input  wire logic [31:0] s_axi_wdata,    // write data
	input  wire logic [3:0]  s_axi_wstrb,    // write byte enables
	input  wire logic        s_axi_wvalid,   // write data valid
	output logic             s_axi_wready,   // write data ready
	output logic [1:0]       s_axi_bresp,    // write response
	output logic             s_axi_bvalid,   // write response valid
	input  wire logic        s_axi_bready,   // write response ready
	input  wire logic [11:0] s_axi_araddr,   // read address
	input  wire logic        s_axi_arvalid,  // read address valid
	output logic             s_axi_arready,  // read address ready
	output logic [31:0]      s_axi_rdata,    // read data
	output logic [1:0]       s_axi_rresp,    // read response
	output logic             s_axi_rvalid,   // read data valid
	input  wire logic        s_axi_rready,   // read data ready
	input  wire eos_pos_t    bitPos,         // position of current bit
	input  wire logic        bitStrobe,      // one pulse per outgoing bit
	input  wire eos_src_t    bitSrc,         // candidate source bits
	output logic             txBitOut,       // selected outgoing bit
	output logic             txBitValid,     // txBitOut updated this cycle
	output logic             hdlcBitTake,    // link bit consumed pulse
	output logic             casEnable,      // CAS signaling active
	output logic             sa4LinkActive   // Sa4 carrying link bits
);

	// software-visible configuration and the write staging
	logic [7:0]  tslsQ;
	logic [7:0]  linkCfgQ;
	logic [11:0] awAddrQ;
	logic        awHeldQ;
	logic [31:0] wDataQ;
	logic [3:0]  wStrbQ;
	logic        wHeldQ;

	// decoded configuration and position flags
	eos_oss_t    ossSel;
	eos_ts16_t   ts16Sel;
	logic [1:0]  linkSrc;
	logic        saInsertReg;
	logic        deAltSel;
	logic        reservedCode;
	logic        casOn;
	logic        natOnes;
	logic        sa4Link;
	logic        isNational;
	logic        isSa4;
	logic        isTs16;
	logic        bitD;
	logic        takeD;

	// fields of the two configuration words
	assign ossSel       = eos_oss_t'(tslsQ[2:0]);
	assign linkSrc      = linkCfgQ[1:0];
	assign saInsertReg  = linkCfgQ[2];
	assign ts16Sel      = eos_ts16_t'(linkCfgQ[4:3]);
	assign deAltSel     = linkCfgQ[5];

	// ---------------- AXI4-Lite write ----------------
	// address and data may arrive in either order; each is held until both are in
	logic doWrite;
	assign doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeldQ       <= 1'b0;
			awAddrQ       <= 12'h000;
			s_axi_awready <= 1'b0;
		end else begin
			// ready pulses, and a held address keeps it low until the store
			s_axi_awready <= !awHeldQ && !s_axi_awready;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeldQ <= 1'b1;
				awAddrQ <= s_axi_awaddr;
			end else if (doWrite) begin
				awHeldQ <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wHeldQ       <= 1'b0;
			wDataQ       <= 32'h0000_0000;
			wStrbQ       <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			// same pacing as the address channel
			s_axi_wready <= !wHeldQ && !s_axi_wready;
			if (s_axi_wvalid && s_axi_wready) begin
				wHeldQ <= 1'b1;
				wDataQ <= s_axi_wdata;
				wStrbQ <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeldQ <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tslsQ        <= TSLS_RESET;
			linkCfgQ     <= LINK_CFG_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// a pending response blocks the store, so one write is in flight at most
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				// registers are one byte wide, so only lane 0 stores
				if (awAddrQ == TSLS_ADDR) begin
					if (wStrbQ[0]) begin
						tslsQ <= {4'h0, wDataQ[3:0]}; // R05
					end
				end else if (awAddrQ == LINK_CFG_ADDR) begin
					if (wStrbQ[0]) begin
						linkCfgQ <= {2'h0, wDataQ[5:0]};
					end
				end else if (awAddrQ == STATUS_ADDR) begin
					// status is read-only: the word is dropped but answered OKAY
					s_axi_bresp <= RESP_OKAY;
				end else begin
					// unmapped offsets store nothing
					s_axi_bresp <= RESP_SLVERR;
				end
			end
		end
	end

	// ---------------- AXI4-Lite read ----------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			// ready pulses and stays low while a read answer is pending
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= RESP_OKAY;
				if (s_axi_araddr == TSLS_ADDR) begin
					s_axi_rdata <= {24'h000000, tslsQ};
				end else if (s_axi_araddr == LINK_CFG_ADDR) begin
					s_axi_rdata <= {24'h000000, linkCfgQ};
				end else if (s_axi_araddr == STATUS_ADDR) begin
					s_axi_rdata <= {29'h0, reservedCode, sa4LinkActive, casEnable};
				end else begin
					// unmapped reads return zero with SLVERR
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			end
		end
	end

	// ---------------- mode decode ----------------
	always_comb begin
		casOn        = 1'b0;
		natOnes      = 1'b0;
		reservedCode = 1'b0;
		case (ossSel)
			OSS_SER_LINK, OSS_DESIG_LINK: begin
				casOn = 1'b0; // R06
			end
			OSS_CAS_LINK: begin
				casOn = 1'b1; // R07
			end
			OSS_SIG_ONES: begin
				natOnes = 1'b1; // R08
			end
			OSS_CAS_ONES: begin
				casOn   = 1'b1; // R09
				natOnes = 1'b1; // R09
			end
			default: begin
				// reserved: no CAS and no link, status shows the bad code
				reservedCode = 1'b1; // R10
			end
		endcase
	end

	// link bits only when enabled, sourced from HDLC and inserted via the serial path
	assign sa4Link = tslsQ[SA4_EN_BIT] && (linkSrc == LINK_SRC_HDLC) && !saInsertReg
		&& !natOnes && !reservedCode; // R03 R04

	// national bits: slot 0 of non-FAS frames, positions Sa4 to Sa8
	assign isNational = bitPos.nonFas && (bitPos.slot == SLOT_FRAMING)
		&& (bitPos.bitPos >= SA4_BIT_POS) && (bitPos.bitPos <= SA8_BIT_POS);
	assign isSa4  = isNational && (bitPos.bitPos == SA4_BIT_POS);
	assign isTs16 = bitPos.slot == SLOT_SIGNALING;

	// ---------------- bit selection ----------------
	always_comb begin
		bitD  = bitSrc.serial;
		takeD = 1'b0;
		// forced ones win over every other national bit source
		if (isNational && natOnes) begin
			bitD = 1'b1; // R08 R09
		end else if (isSa4) begin
			// register-sourced Sa4 bypasses the link, so no link bit is consumed
			if (saInsertReg) begin
				bitD = bitSrc.saReg;
			end else if (sa4Link) begin
				// take pulse lets the link source advance only on bits sent
				bitD  = bitSrc.hdlc; // R03
				takeD = 1'b1;
			end else begin
				bitD = 1'b1; // R01 R02
			end
		end else if (isTs16) begin
			// a sub-source the code does not offer stays on the serial input
			case (ossSel)
				OSS_CAS_LINK: begin
					// signaling input is not offered with this code
					if (ts16Sel == TS16_REGS) begin
						bitD = bitSrc.casReg; // R07
					end else if (ts16Sel == TS16_OVHD) begin
						bitD = bitSrc.overhead; // R07
					end
				end
				OSS_SIG_ONES: begin
					if (ts16Sel == TS16_SIGIN) begin
						bitD = bitSrc.signaling; // R08
					end
				end
				OSS_CAS_ONES: begin
					if (ts16Sel == TS16_REGS) begin
						bitD = bitSrc.casReg; // R09
					end else if (ts16Sel == TS16_OVHD) begin
						bitD = bitSrc.overhead; // R09
					end else if (ts16Sel == TS16_SIGIN) begin
						bitD = bitSrc.signaling; // R09
					end
				end
				default: begin
					bitD = bitSrc.serial; // R06
				end
			endcase
		end else if (bitPos.deSlot && deAltSel) begin
			// alternate D/E source depends on the code
			bitD = (ossSel == OSS_DESIG_LINK) ? bitSrc.signaling : bitSrc.fractional; // R06
		end
	end

	// the bit holds between strobes so the framer may sample it late
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			txBitOut <= 1'b1;
		end else if (bitStrobe) begin
			txBitOut <= bitD; // R05
		end
	end

	// one-cycle pulses marking each new bit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			txBitValid  <= 1'b0;
			hdlcBitTake <= 1'b0;
		end else begin
			txBitValid  <= bitStrobe;
			hdlcBitTake <= bitStrobe && takeD;
		end
	end

	// status flags lag a register write by one cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			casEnable     <= 1'b0;
			sa4LinkActive <= 1'b0;
		end else begin
			casEnable     <= casOn;
			sa4LinkActive <= sa4Link;
		end
	end

endmodule : eos_source_select

// ### eos_source_select_checker.sv
`timescale 1ns/1ps
module eos_source_select_checker
	import eos_pkg::*;
(
	input wire logic        sys_clk,       // clock
	input wire logic        rst_n,         // reset
	input wire eos_pos_t    bitPos,        // bit position
	input wire logic        bitStrobe,     // bit strobe
	input wire eos_src_t    bitSrc,        // candidates
	input wire logic        txBitOut,      // chosen bit
	input wire logic        txBitValid,    // bit pulse
	input wire logic        hdlcBitTake,   // link take
	input wire logic        casEnable,     // cas on
	input wire logic        sa4LinkActive, // sa4 link
	input wire logic        s_axi_bvalid,  // bvalid
	input wire logic        s_axi_bready,  // bready
	input wire logic [1:0]  s_axi_bresp,   // bresp
	input wire logic        s_axi_rvalid,  // rvalid
	input wire logic        s_axi_rready,  // rready
	input wire logic [31:0] s_axi_rdata    // rdata
);
	wire logic atSa4 = bitPos.nonFas && bitPos.slot == SLOT_FRAMING && bitPos.bitPos == SA4_BIT_POS;
	// ordinary slots never depend on the select code
	wire logic plain = bitPos.slot != SLOT_FRAMING && bitPos.slot != SLOT_SIGNALING && !bitPos.deSlot;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	AST_BIT_VALID: assert property (bitStrobe |=> txBitValid)
		else $error("no bit pulse after strobe");
	AST_BIT_HOLD: assert property (!bitStrobe |=> !txBitValid && $stable(txBitOut))
		else $error("bit moved without strobe");
	AST_SA4_OFF: assert property (bitStrobe && atSa4 |=> sa4LinkActive || !hdlcBitTake)
		else $error("link bit taken while sa4 link off");
	AST_SA4_LINK: assert property (bitStrobe && atSa4 |=> !sa4LinkActive || (hdlcBitTake && txBitOut == $past(bitSrc.hdlc)))
		else $error("sa4 not carrying link bit");
	AST_TAKE_ONLY_SA4: assert property (bitStrobe && !atSa4 |=> !hdlcBitTake)
		else $error("link bit taken outside sa4");
	AST_PLAIN_SLOT: assert property (bitStrobe && plain |=> txBitOut == $past(bitSrc.serial))
		else $error("ordinary slot not from serial");
	AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	cover property (hdlcBitTake);
	cover property ($rose(casEnable));
	cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : eos_source_select_checker

bind eos_source_select eos_source_select_checker u_eos_source_select_checker(.sys_clk, .rst_n, .bitPos,
	.bitStrobe, .bitSrc, .txBitOut, .txBitValid, .hdlcBitTake, .casEnable, .sa4LinkActive, .s_axi_bvalid,
	.s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// ### eos_backplane_model.sv
`timescale 1ns/1ps
module eos_backplane_model
	import eos_pkg::*;
(
	input  wire logic sys_clk, // clock
	input  wire logic rst_n,   // reset
	output eos_src_t  src      // candidate bits
);
	// new data every cycle so a stale sample matches only by luck
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			src <= '0;
		else
			src <= eos_src_t'($urandom);
	end
endmodule : eos_backplane_model

// ### eos_source_select_tb_top.sv
`timescale 1ns/1ps
module eos_source_select_tb_top;
	import eos_pkg::*;
	logic        sys_clk, rst_n, bitStrobe, txBitOut, txBitValid, hdlcBitTake, casEnable, sa4LinkActive;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, en, e, t;
	eos_pos_t    bitPos;
	eos_src_t    bitSrc;
	logic [2:0]  code;
	logic [5:0]  cfg;
	int          num_errors, cmp_count, cyc;

	eos_source_select u_eos_source_select(.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .bitPos, .bitStrobe, .bitSrc, .txBitOut, .txBitValid, .hdlcBitTake, .casEnable,
		.sa4LinkActive);
	eos_backplane_model u_eos_backplane_model(.sys_clk, .rst_n, .src(bitSrc));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task summarize();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 6000) begin
			num_errors++;
			summarize();
		end
	end

	task axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask : axw

	task axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask : axr

	function logic linkOn();
		return en && cfg[1:0] == LINK_SRC_HDLC && !cfg[2] && (code == 3'h0 || code == 3'h1 || code == 3'h4);
	endfunction : linkOn

	function logic expBit(eos_pos_t p, eos_src_t s);
		logic nat;
		nat = p.nonFas && p.slot == SLOT_FRAMING;
		if (nat && p.bitPos == SA4_BIT_POS && linkOn())
			return s.hdlc;
		if (nat && (code == 3'h2 || code == 3'h3))
			return 1'b1;
		if (nat && p.bitPos == SA4_BIT_POS)
			return cfg[2] ? s.saReg : 1'b1;
		if (nat)
			return s.serial;
		if (p.slot == SLOT_SIGNALING) begin
			if (code > 3'h4)
				return s.serial;
			if (code[0] && cfg[4:3] == 2'h1)
				return s.casReg;
			if (code[0] && cfg[4:3] == 2'h2)
				return s.overhead;
			if (code[1] && cfg[4:3] == 2'h3)
				return s.signaling;
			return s.serial;
		end
		if (p.deSlot && cfg[5])
			return code == 3'h4 ? s.signaling : s.fractional;
		return s.serial;
	endfunction : expBit

	function eos_pos_t pick(int j);
		if (j == 0)
			return '{1'b1, SLOT_FRAMING, SA4_BIT_POS, 1'b0};
		case (j % 4)
			0: return '{1'b1, SLOT_FRAMING, 3'(3 + $urandom_range(4)), 1'b0};
			1: return '{1'b0, SLOT_SIGNALING, 3'($urandom), 1'b0};
			2: return '{1'b0, 5'(1 + $urandom_range(14)), 3'($urandom), 1'($urandom)};
			default: return '{1'b0, 5'(17 + $urandom_range(14)), 3'($urandom), 1'b0};
		endcase
	endfunction : pick

	initial begin
		{rst_n, bitStrobe, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, bitPos} = '0;
		s_axi_wstrb = 4'hF;
		void'($urandom(88));
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		axr(TSLS_ADDR, rd, rs);
		check(rd, 32'h0);
		axr(12'h7F0, rd, rs);
		check(rs, RESP_SLVERR);
		axw(12'h7F0, 32'hFF, rs);
		check(rs, RESP_SLVERR);
		for (int i = 0; i < 40; i++) begin
			code = i < 8 ? i[2:0] : 3'($urandom);
			en = i < 8 ? 1'b1 : 1'($urandom);
			cfg = i < 8 ? {3'($urandom), 3'h1} : 6'($urandom);
			axw(LINK_CFG_ADDR, {26'h0, cfg}, rs);
			// upper bits must read back as zero
			axw(TSLS_ADDR, {24'($urandom), 4'($urandom), en, code}, rs);
			axr(TSLS_ADDR, rd, rs);
			check(rd, {28'h0, en, code});
			axr(STATUS_ADDR, rd, rs);
			check(rd, {29'h0, code > 3'h4, linkOn(), code == 3'h1 || code == 3'h3});
			check(sa4LinkActive, linkOn());
			check(casEnable, code == 3'h1 || code == 3'h3);
			for (int j = 0; j < 9; j++) begin
				bitStrobe <= j < 8;
				bitPos <= pick(j);
				@(posedge sys_clk);
				if (j > 0) begin
					check(txBitOut, e);
					check(hdlcBitTake, t);
				end
				e = expBit(bitPos, bitSrc);
				t = linkOn() && bitPos.nonFas && bitPos.slot == SLOT_FRAMING && bitPos.bitPos == SA4_BIT_POS;
			end
		end
		summarize();
	end
endmodule : eos_source_select_tb_top
